/* verilog/lio_pkg.sv */
// constants, types and decode helpers of the legacy i/o decoder
// assumes one clock domain; every file names members as lio_pkg::name
package lio_pkg;

    // width of a decoded i/o address, bit 16 is the wrap bit
    localparam int IO_ADDR_W = 17;

    // fixed port bases and their don't-care (alias) bits
    localparam logic [15:0] OFS_DMA1 = 16'h0000;
    localparam logic [15:0] DC_DMA1 = 16'h001f;
    localparam logic [15:0] OFS_PIC = 16'h0020;
    localparam logic [15:0] DC_PIC = 16'h001d;
    localparam logic [15:0] OFS_TMR = 16'h0040;
    localparam logic [15:0] DC_TMR = 16'h0013;
    localparam logic [15:0] OFS_KBD_DATA = 16'h0060;
    localparam logic [15:0] OFS_KBD_ALIAS = 16'h0062;
    localparam logic [15:0] OFS_KBD_STAT = 16'h0064;
    localparam logic [15:0] OFS_NMI = 16'h0061;
    localparam logic [15:0] DC_NMI = 16'h0006;
    localparam logic [15:0] OFS_RTC = 16'h0070;
    localparam logic [15:0] DC_RTC = 16'h0007;
    localparam logic [2:0] RTC_XIDX_LOW = 3'h2;
    localparam logic [2:0] RTC_XDATA_LOW = 3'h3;

    // low nibble of the first dma controller ports
    localparam logic [3:0] SUB_CMDSTAT = 4'h8;
    localparam logic [3:0] SUB_SMASK = 4'ha;
    localparam logic [3:0] SUB_CLRPTR = 4'hc;
    localparam logic [3:0] SUB_MCLR = 4'hd;
    localparam logic [3:0] SUB_CLRMSK = 4'he;
    localparam logic [3:0] SUB_ALLMSK = 4'hf;

    // values after reset, and the mask value after a master clear
    localparam logic [7:0] RST_DMA_CMD = 8'h00;
    localparam logic [7:0] RST_DMA_STAT = 8'h00;
    localparam logic [3:0] RST_ALLMASK = 4'h1;
    localparam logic [3:0] SET_ALLMASK = 4'hf;
    localparam logic [7:0] RST_NMI = 8'h00;
    localparam logic [7:0] RST_RTC_XIDX = 8'h00;

    // claim timing, cycles after the address phase
    localparam logic [2:0] MED_DEVSEL_CYC = 3'h2;
    localparam logic [2:0] SUB_DEVSEL_CYC = 3'h4;

    typedef enum logic [4:0] {
        HIT_NONE = 5'h00, HIT_DMA_CH = 5'h01, HIT_DMA_CS = 5'h02, HIT_DMA_SMASK = 5'h03,
        HIT_DMA_CLRPTR = 5'h04, HIT_DMA_MCLR = 5'h05, HIT_DMA_CLRMSK = 5'h06,
        HIT_DMA_ALLMSK = 5'h07, HIT_DMA_OTHER = 5'h08, HIT_PIC = 5'h09, HIT_TMR = 5'h0a,
        HIT_KBD_DATA = 5'h0b, HIT_KBD_STAT = 5'h0c, HIT_NMI = 5'h0d, HIT_RTC = 5'h0e,
        HIT_RTC_X = 5'h0f, HIT_VAR = 5'h10
    } lio_hit_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_DECODE = 3'b001, ST_LOCAL = 3'b010,
        ST_EXTIO = 3'b011, ST_FINISH = 3'b100
    } lio_state_type;

    // address matches base where the don't-care bits are ignored
    function automatic logic inRange(input logic [15:0] a, input logic [15:0] base, input logic [15:0] dc);
        return ((a ^ base) & ~dc) == 16'h0000;
    endfunction

endpackage

/* verilog/lio_mem.sv */
// small byte store for the dma channel address and count ports
// assumes one clock; contents have no reset value, read data is registered
`timescale 1ns/1ps
module lio_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 4
) (
    // clock
    input wire logic core_clk,
    // write side
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    // read side
    input wire logic [ADDR_W-1:0] rdAddr,
    output logic [DATA_W-1:0] rdData_q
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // no reset on purpose: these ports power up undefined
    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_q <= mem[rdAddr];
    end

endmodule

/* verilog/lio_decode.sv */
// fixed and variable range decode of one latched i/o address
// assumes a stable address; purely combinational
`timescale 1ns/1ps
module lio_decode #(
    parameter int VAR_SPAN_W = 4
) (
    // address and modes
    input wire logic [lio_pkg::IO_ADDR_W-1:0] ioAddr,
    input wire logic rtcIntEn,
    input wire logic rtcExtRamEn,
    input wire logic kbdCtrlFwdEn,
    input wire logic rtcXFwdEn,
    input wire logic [15:0] varBase,
    input wire logic varEn,
    // results
    output lio_pkg::lio_hit_type hit,
    output logic posHit,
    output logic fwdExtIo,
    output logic kbdDataAddr
);

    localparam logic [15:0] VAR_DC = 16'((32'h1 << VAR_SPAN_W) - 1);

    logic [15:0] a;
    logic low;
    logic dmaWin, picWin, tmrWin, nmiWin, rtcWin, rtcXSel, kbdStat, varHit;
    lio_pkg::lio_hit_type dmaHit;

    // wrapped locations never match a fixed port
    assign a = ioAddr[15:0];
    assign low = !ioAddr[16];
    assign dmaWin = low && lio_pkg::inRange(a, lio_pkg::OFS_DMA1, lio_pkg::DC_DMA1);
    assign picWin = low && lio_pkg::inRange(a, lio_pkg::OFS_PIC, lio_pkg::DC_PIC);
    assign tmrWin = low && lio_pkg::inRange(a, lio_pkg::OFS_TMR, lio_pkg::DC_TMR);
    assign nmiWin = low && lio_pkg::inRange(a, lio_pkg::OFS_NMI, lio_pkg::DC_NMI);
    assign kbdDataAddr = low && (a == lio_pkg::OFS_KBD_DATA || a == lio_pkg::OFS_KBD_ALIAS);
    assign kbdStat = low && a == lio_pkg::OFS_KBD_STAT;
    assign rtcWin = low && lio_pkg::inRange(a, lio_pkg::OFS_RTC, lio_pkg::DC_RTC);
    // extended ram steals the 072/073 aliases
    assign rtcXSel = rtcWin && rtcExtRamEn &&
        (a[2:0] == lio_pkg::RTC_XIDX_LOW || a[2:0] == lio_pkg::RTC_XDATA_LOW);
    assign varHit = low && varEn && lio_pkg::inRange(a, varBase, VAR_DC);

    // dma controller sub-port select
    assign dmaHit = !a[3] ? lio_pkg::HIT_DMA_CH :
        a[3:0] == lio_pkg::SUB_CMDSTAT ? lio_pkg::HIT_DMA_CS :
        a[3:0] == lio_pkg::SUB_SMASK ? lio_pkg::HIT_DMA_SMASK :
        a[3:0] == lio_pkg::SUB_CLRPTR ? lio_pkg::HIT_DMA_CLRPTR :
        a[3:0] == lio_pkg::SUB_MCLR ? lio_pkg::HIT_DMA_MCLR :
        a[3:0] == lio_pkg::SUB_CLRMSK ? lio_pkg::HIT_DMA_CLRMSK :
        a[3:0] == lio_pkg::SUB_ALLMSK ? lio_pkg::HIT_DMA_ALLMSK : lio_pkg::HIT_DMA_OTHER;

    // fixed ranges first, disabled ranges fall through
    assign hit = dmaWin ? dmaHit :
        picWin ? lio_pkg::HIT_PIC :
        tmrWin ? lio_pkg::HIT_TMR :
        nmiWin ? lio_pkg::HIT_NMI :
        (kbdDataAddr && kbdCtrlFwdEn) ? lio_pkg::HIT_KBD_DATA :
        (kbdStat && kbdCtrlFwdEn) ? lio_pkg::HIT_KBD_STAT :
        rtcXSel ? lio_pkg::HIT_RTC_X :
        (rtcWin && rtcIntEn) ? lio_pkg::HIT_RTC :
        varHit ? lio_pkg::HIT_VAR : lio_pkg::HIT_NONE;

    assign posHit = hit != lio_pkg::HIT_NONE;
    assign fwdExtIo = hit == lio_pkg::HIT_KBD_DATA || hit == lio_pkg::HIT_KBD_STAT ||
        (hit == lio_pkg::HIT_RTC_X && rtcXFwdEn) || hit == lio_pkg::HIT_VAR;

endmodule

/* verilog/lio_decoder.sv */
// i/o cycle router and fixed-range claim logic of the bridge
// assumes requests synchronous to core_clk, one cycle in flight at a time
//
// Operation
// - broadcast non-config i/o, then claim it
// - decode 64k plus three wrapped bytes
// - addresses pass through without translation
// - writes complete only after target accepts
// - fixed ranges fixed, some individually disableable
// - variable range has programmable base, enable
// - fixed ranges claimed at medium timing
// - unlisted addresses claimed subtractively only if enabled
// - dma channel ports local, alias, undefined
// - dma command write, status read, zero reset
// - mask write-only, clears are data-less strobes
// - all-mask readable, writable, resets to one
// - timer ports with alias, never forwarded
// - keyboard data read clears expansion irqs
// - nmi register with odd aliases, zero reset
// - rtc index alias only without extended ram
// - rtc data alias stops with extended ram
// - extended rtc index, forwarded when enabled
// - external config accesses broadcast on pci
`timescale 1ns/1ps
module lio_decoder #(
    parameter int VAR_SPAN_W = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // cycle request from the internal bus
    input wire logic cycReq,
    input wire logic [15:0] cycAddr,
    input wire logic ioWrapAddrBit,
    input wire logic cycWrite,
    input wire logic [7:0] cycWdata,
    input wire logic cycIsCfg,
    input wire logic cycCfgInternal,
    // cycle completion
    output logic cycBusy,
    output logic cycDone,
    output logic cycClaimed,
    output logic [7:0] cycRdata,
    // external pci broadcast
    output logic extPciStart,
    output logic extPciCfg,
    output logic extPciWrite,
    output logic [lio_pkg::IO_ADDR_W-1:0] extPciAddr,
    input wire logic extPciClaim,
    // claim selects
    output logic posSel,
    output logic subSel,
    // extended i/o bus
    output logic extIoStb,
    input wire logic extIoAck,
    input wire logic [7:0] extIoRdata,
    // internal peripherals
    output logic periphStb,
    output lio_pkg::lio_hit_type periphHit,
    output logic [7:0] ioWdata,
    input wire logic [7:0] periphRdata,
    // first dma controller
    input wire logic [7:0] dmaStatusIn,
    output logic [7:0] dmaCmd,
    output logic [3:0] dmaMask,
    output logic dmaMasterClr,
    output logic dmaMaskStb,
    // nmi, keyboard, clock
    output logic [7:0] nmiCtl,
    output logic kbdIrqClr,
    output logic [7:0] rtcXIndex,
    // configuration
    input wire logic subtractiveEn,
    input wire logic rtcIntEn,
    input wire logic rtcExtRamEn,
    input wire logic kbdCtrlFwdEn,
    input wire logic rtcXFwdEn,
    input wire logic [15:0] varBase,
    input wire logic varEn
);

    lio_pkg::lio_state_type state_q, state_d;
    logic [2:0] cnt_q;
    logic [lio_pkg::IO_ADDR_W-1:0] addr_q;
    logic write_q, cfg_q, ptr_q;
    logic [7:0] wdata_q, rdata_q, dmaCmd_q, dmaStat_q, dmaStat_d, nmi_q, rtcX_q;
    logic [3:0] allMask_q, allMask_d, chBit;
    logic posSel_q, subSel_q, extStart_q, extIoStb_q, periphStb_q;
    logic kbdClr_q, mclr_q, maskStb_q;
    lio_pkg::lio_hit_type hit;
    logic posHit, fwdExtIo, kbdDataAddr;
    logic accept, goPos, goSub, wrNow, rdNow, inDecode;
    logic memWe, isPeriph, stClr;
    logic [7:0] memRd, localRd;

    lio_decode #(.VAR_SPAN_W(VAR_SPAN_W)) u_decode (
        .ioAddr(addr_q),
        .rtcIntEn(rtcIntEn),
        .rtcExtRamEn(rtcExtRamEn),
        .kbdCtrlFwdEn(kbdCtrlFwdEn),
        .rtcXFwdEn(rtcXFwdEn),
        .varBase(varBase),
        .varEn(varEn),
        .hit(hit),
        .posHit(posHit),
        .fwdExtIo(fwdExtIo),
        .kbdDataAddr(kbdDataAddr)
    );

    // channel bytes addressed by port and byte pointer
    lio_mem #(.DATA_W(8), .ADDR_W(4)) u_mem (
        .core_clk(core_clk),
        .wrEn(memWe),
        .wrAddr({addr_q[2:0], ptr_q}),
        .wrData(wdata_q),
        .rdAddr({addr_q[2:0], ptr_q}),
        .rdData_q(memRd)
    );

    // cycle events
    assign accept = state_q == lio_pkg::ST_IDLE && cycReq;
    assign inDecode = state_q == lio_pkg::ST_DECODE && !cfg_q;
    assign goPos = inDecode && posHit && cnt_q == lio_pkg::MED_DEVSEL_CYC - 3'h1;
    assign goSub = inDecode && !posHit && !extPciClaim && subtractiveEn &&
        cnt_q == lio_pkg::SUB_DEVSEL_CYC - 3'h1;
    assign wrNow = goPos && write_q;
    // status clears only once its value has gone into the answer
    assign rdNow = state_q == lio_pkg::ST_LOCAL && !write_q;
    assign memWe = wrNow && hit == lio_pkg::HIT_DMA_CH;
    assign isPeriph = hit == lio_pkg::HIT_PIC || hit == lio_pkg::HIT_TMR || hit == lio_pkg::HIT_RTC;
    assign stClr = rdNow && hit == lio_pkg::HIT_DMA_CS;

    // next state; internal config cycles finish at once, external ones wait out the window unclaimed
    always_comb begin
        state_d = state_q;
        case (state_q)
            lio_pkg::ST_IDLE: begin
                if (cycReq) begin
                    state_d = (cycIsCfg && cycCfgInternal) ? lio_pkg::ST_FINISH : lio_pkg::ST_DECODE;
                end
            end
            lio_pkg::ST_DECODE: begin
                if (goPos) begin
                    state_d = fwdExtIo ? lio_pkg::ST_EXTIO : lio_pkg::ST_LOCAL;
                end else if (goSub) begin
                    state_d = lio_pkg::ST_EXTIO;
                end else if ((extPciClaim && !posHit) || cnt_q == lio_pkg::SUB_DEVSEL_CYC - 3'h1) begin
                    state_d = lio_pkg::ST_FINISH;
                end
            end
            lio_pkg::ST_LOCAL: state_d = lio_pkg::ST_FINISH;
            lio_pkg::ST_EXTIO: begin
                if (extIoAck) begin
                    state_d = lio_pkg::ST_FINISH;
                end
            end
            lio_pkg::ST_FINISH: state_d = lio_pkg::ST_IDLE;
            default: state_d = lio_pkg::ST_IDLE;
        endcase
    end

    // state and decode window counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= lio_pkg::ST_IDLE;
            cnt_q <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_q == lio_pkg::ST_DECODE) ? cnt_q + 3'h1 : 3'h0;
        end
    end

    // latch the cycle untranslated, wrap bit on top
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_q <= 17'h00000;
            write_q <= 1'b0;
            cfg_q <= 1'b0;
            wdata_q <= 8'h00;
        end else if (accept) begin
            addr_q <= {ioWrapAddrBit, cycAddr};
            write_q <= cycWrite;
            cfg_q <= cycIsCfg;
            wdata_q <= cycWdata;
        end
    end

    // broadcast strobe; internal config registers never reach pci
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            extStart_q <= 1'b0;
        end else begin
            extStart_q <= accept && !(cycIsCfg && cycCfgInternal);
        end
    end

    // target selects stay up until the cycle finishes
    always_ff @(posedge core_clk) begin
        if (!rst_n || state_q == lio_pkg::ST_FINISH) begin
            posSel_q <= 1'b0;
            subSel_q <= 1'b0;
        end else begin
            posSel_q <= posSel_q || goPos;
            subSel_q <= subSel_q || goSub;
        end
    end

    // one-cycle strobes toward the far targets
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            extIoStb_q <= 1'b0;
            periphStb_q <= 1'b0;
            kbdClr_q <= 1'b0;
        end else begin
            extIoStb_q <= (goPos && fwdExtIo) || goSub;
            periphStb_q <= goPos && isPeriph;
            kbdClr_q <= inDecode && cnt_q == 3'h0 && !write_q && kbdDataAddr;
        end
    end

    // status is sticky: a new status bit beats the read clear
    assign dmaStat_d = ((stClr || mclr_q) ? lio_pkg::RST_DMA_STAT : dmaStat_q) | dmaStatusIn;

    // channel mask updates; write data of the clears is ignored
    assign chBit = 4'h1 << wdata_q[1:0];
    assign allMask_d = (wrNow && hit == lio_pkg::HIT_DMA_MCLR) ? lio_pkg::SET_ALLMASK :
        (wrNow && hit == lio_pkg::HIT_DMA_CLRMSK) ? 4'h0 :
        (wrNow && hit == lio_pkg::HIT_DMA_SMASK) ? ((allMask_q & ~chBit) | (wdata_q[2] ? chBit : 4'h0)) :
        (wrNow && hit == lio_pkg::HIT_DMA_ALLMSK) ? wdata_q[3:0] : allMask_q;

    // first dma controller state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dmaCmd_q <= lio_pkg::RST_DMA_CMD;
            dmaStat_q <= lio_pkg::RST_DMA_STAT;
            allMask_q <= lio_pkg::RST_ALLMASK;
            ptr_q <= 1'b0;
            mclr_q <= 1'b0;
            maskStb_q <= 1'b0;
        end else begin
            dmaCmd_q <= (wrNow && hit == lio_pkg::HIT_DMA_CS) ? wdata_q : dmaCmd_q;
            dmaStat_q <= dmaStat_d;
            allMask_q <= allMask_d;
            mclr_q <= wrNow && hit == lio_pkg::HIT_DMA_MCLR;
            maskStb_q <= wrNow && hit == lio_pkg::HIT_DMA_SMASK;
            // pointer flips per channel byte, cleared by its port
            if (wrNow && (hit == lio_pkg::HIT_DMA_CLRPTR || hit == lio_pkg::HIT_DMA_MCLR)) begin
                ptr_q <= 1'b0;
            end else if (goPos && hit == lio_pkg::HIT_DMA_CH) begin
                ptr_q <= !ptr_q;
            end
        end
    end

    // nmi and extended clock index; stored even when forwarded, odd address is the data port
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nmi_q <= lio_pkg::RST_NMI;
            rtcX_q <= lio_pkg::RST_RTC_XIDX;
        end else begin
            nmi_q <= (wrNow && hit == lio_pkg::HIT_NMI) ? wdata_q : nmi_q;
            rtcX_q <= (wrNow && hit == lio_pkg::HIT_RTC_X && !addr_q[0]) ? wdata_q : rtcX_q;
        end
    end

    // local read data; write-only ports read as zero
    assign localRd = hit == lio_pkg::HIT_DMA_CH ? memRd :
        hit == lio_pkg::HIT_DMA_CS ? dmaStat_q :
        hit == lio_pkg::HIT_DMA_ALLMSK ? {4'h0, allMask_q} :
        hit == lio_pkg::HIT_NMI ? nmi_q :
        (hit == lio_pkg::HIT_RTC_X && !addr_q[0]) ? rtcX_q :
        isPeriph ? periphRdata : 8'h00;

    // answer data captured when the target completes; writes answer zero
    always_ff @(posedge core_clk) begin
        if (!rst_n || accept) begin
            rdata_q <= 8'h00;
        end else if (rdNow) begin
            rdata_q <= localRd;
        end else if (state_q == lio_pkg::ST_EXTIO && extIoAck && !write_q) begin
            rdata_q <= extIoRdata;
        end
    end

    // outputs
    assign cycBusy = state_q != lio_pkg::ST_IDLE;
    assign cycDone = state_q == lio_pkg::ST_FINISH;
    assign cycClaimed = posSel_q || subSel_q;
    assign cycRdata = rdata_q;
    assign extPciStart = extStart_q;
    assign extPciCfg = cfg_q;
    assign extPciWrite = write_q;
    assign extPciAddr = addr_q;
    assign posSel = posSel_q;
    assign subSel = subSel_q;
    assign extIoStb = extIoStb_q;
    assign periphStb = periphStb_q;
    assign periphHit = hit;
    assign ioWdata = wdata_q;
    assign dmaCmd = dmaCmd_q;
    assign dmaMask = allMask_q;
    assign dmaMasterClr = mclr_q;
    assign dmaMaskStb = maskStb_q;
    assign nmiCtl = nmi_q;
    assign kbdIrqClr = kbdClr_q;
    assign rtcXIndex = rtcX_q;

    oneSel_a: assert property (@(posedge core_clk) disable iff (!rst_n) !(posSel && subSel))
        else $error("both target selects high");
    posTime_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(posSel) |-> $past(cnt_q) == 3'h1 && $past(posHit) && !$past(cfg_q))
        else $error("positive claim not at medium timing");
    subGate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(subSel) |-> $past(subtractiveEn) && !$past(posHit) && $past(cnt_q) == 3'h3)
        else $error("subtractive claim without mode or too early");
    noPost_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == lio_pkg::ST_EXTIO && !extIoAck |=> !cycDone)
        else $error("forwarded cycle completed before target ack");
    addrPass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept ##1 extPciStart |-> extPciAddr == {$past(ioWrapAddrBit), $past(cycAddr)})
        else $error("broadcast address differs from request");
    cfgBcast_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        accept && cycIsCfg && !cycCfgInternal |=> extPciStart && extPciCfg ##1 !extPciStart)
        else $error("external config access not broadcast");
    dmaLocal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        extIoStb |-> hit != lio_pkg::HIT_DMA_CH && hit != lio_pkg::HIT_TMR && hit != lio_pkg::HIT_NMI)
        else $error("never-forwarded port sent to expansion bus");
    kbdClr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        kbdIrqClr |-> !write_q && kbdDataAddr && !cfg_q ##1 !kbdIrqClr)
        else $error("keyboard irq clear without data read");
    maskRst_a: assert property (@(posedge core_clk)
        rst_n && $past(!rst_n) |-> dmaMask == 4'h1 && nmiCtl == 8'h00)
        else $error("mask or nmi reset value wrong");
    noWrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_q[16] |-> hit == lio_pkg::HIT_NONE)
        else $error("wrapped location decoded as fixed port");
    rdClr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        stClr |=> cycRdata == $past(dmaStat_q) && dmaStat_q == $past(dmaStatusIn))
        else $error("status read data or clear wrong");
    wrZero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        cycDone && write_q |-> cycRdata == 8'h00)
        else $error("write cycle returned read data");
    nmiHold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(wrNow && hit == lio_pkg::HIT_NMI) |=> $stable(nmiCtl))
        else $error("nmi register changed without a write");

endmodule

/* verif/lio_exp_model.sv */
// expansion bus target that answers each strobe after a settable wait
// assumes one-cycle strobes and one transfer in flight at a time
`timescale 1ns/1ps
module lio_exp_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // bus side
    input wire logic extIoStb,
    input wire logic [3:0] waitCyc,
    output logic extIoAck,
    output logic [7:0] extIoRdata
);
    logic [4:0] cnt;
    logic busy;
    // lines toggle while no answer stands, so a stale byte never matches
    assign extIoRdata = extIoAck ? 8'h96 : (cnt[0] ? 8'h55 : 8'haa);
    // accept only after the wait; a write must not end any sooner
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 5'h00;
            extIoAck <= 1'b0;
        end else begin
            extIoAck <= 1'b0;
            cnt <= cnt + 5'h01;
            if (extIoStb) begin
                busy <= 1'b1;
                cnt <= 5'h00;
            end else if (busy && cnt == {1'b0, waitCyc}) begin
                busy <= 1'b0;
                extIoAck <= 1'b1;
            end
        end
    end
endmodule

/* verif/testbench.sv */
// self-checking bench of the legacy i/o decoder with an expansion target
// assumes the decoder answers one cycle at a time, as handed over
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst_n, cycReq, ioWrapAddrBit, cycWrite, cycIsCfg, cycCfgInternal, extPciClaim;
    logic [15:0] cycAddr, seed, varBase;
    logic [7:0] cycWdata, periphRdata, dmaStatusIn, r, h;
    logic subtractiveEn, rtcIntEn, rtcExtRamEn, kbdCtrlFwdEn, rtcXFwdEn, varEn;
    logic cycBusy, cycDone, cycClaimed, extPciStart, extPciCfg, extPciWrite, posSel, subSel;
    logic extIoStb, extIoAck, periphStb, dmaMasterClr, dmaMaskStb, kbdIrqClr;
    logic [7:0] cycRdata, extIoRdata, ioWdata, dmaCmd, nmiCtl, rtcXIndex;
    logic [16:0] extPciAddr;
    logic [3:0] dmaMask, waitCyc;
    lio_pkg::lio_hit_type periphHit;
    logic [26:0] notes[$];
    logic [26:0] n;
    int mismatches = 0, total_checks = 0, ackCnt = 0, kbdCnt = 0, stCnt = 0, k0;
    lio_decoder dut (.core_clk, .rst_n, .cycReq, .cycAddr, .ioWrapAddrBit, .cycWrite, .cycWdata, .cycIsCfg,
        .cycCfgInternal, .cycBusy, .cycDone, .cycClaimed, .cycRdata, .extPciStart, .extPciCfg, .extPciWrite,
        .extPciAddr, .extPciClaim, .posSel, .subSel, .extIoStb, .extIoAck, .extIoRdata, .periphStb, .periphHit,
        .ioWdata, .periphRdata, .dmaStatusIn, .dmaCmd, .dmaMask, .dmaMasterClr, .dmaMaskStb, .nmiCtl, .kbdIrqClr,
        .rtcXIndex, .subtractiveEn, .rtcIntEn, .rtcExtRamEn, .kbdCtrlFwdEn, .rtcXFwdEn, .varBase, .varEn);
    lio_exp_model model (.core_clk, .rst_n, .extIoStb, .waitCyc, .extIoAck, .extIoRdata);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one whole cycle: note the answer, pulse the request, wait for the end
    task automatic io(input logic [16:0] a, input logic wr, input logic [7:0] wd, input logic [1:0] cfg,
                      input logic [8:0] exp, input int fwd);
        int b;
        b = ackCnt;
        @(posedge core_clk);
        notes.push_back({cfg != 2'b11, a, exp});
        {ioWrapAddrBit, cycAddr} <= a;
        {cycIsCfg, cycCfgInternal} <= cfg;
        cycWrite <= wr;
        cycWdata <= wd;
        cycReq <= 1'b1;
        @(posedge core_clk);
        cycReq <= 1'b0;
        repeat (60) begin
            #1;
            if (cycDone === 1'b1) break;
            @(posedge core_clk);
        end
        if (cycDone !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end else begin
            check(ackCnt - b, fwd);
        end
    endtask
    // watcher: pairs every finished cycle with the oldest note
    always @(posedge core_clk) begin
        if (extIoAck === 1'b1) ackCnt++;
        if (kbdIrqClr === 1'b1) kbdCnt++;
        if (extPciStart === 1'b1) stCnt++;
        if (cycDone === 1'b1) begin
            n = notes.pop_front();
            check({cycClaimed, cycRdata}, n[8:0]);
            if (n[26]) check(extPciAddr, n[25:9]);
        end
    end
    initial begin
        {cycReq, ioWrapAddrBit, cycWrite, cycIsCfg, cycCfgInternal, extPciClaim, subtractiveEn} = 7'h00;
        {rtcIntEn, rtcExtRamEn, kbdCtrlFwdEn, rtcXFwdEn, varEn} = 5'h00;
        {cycAddr, cycWdata, dmaStatusIn, varBase} = 48'h0000_0000_0000;
        periphRdata = 8'h5a;
        waitCyc = 4'h1;
        seed = 16'hbfef;
        rst_n = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check(dmaCmd, 8'h00);
        check(dmaMask, 4'h1);
        check(nmiCtl, 8'h00);
        check(rtcXIndex, 8'h00);
        $display("test reset done");
        seed = lfsr(seed);
        r = seed[7:0];
        io(17'h00008, 1, r, 0, 9'h100, 0);
        check(dmaCmd, r);
        io(17'h00018, 0, 0, 0, 9'h100, 0);
        @(posedge core_clk);
        dmaStatusIn <= 8'h03;
        @(posedge core_clk);
        dmaStatusIn <= 8'h00;
        io(17'h00008, 0, 0, 0, 9'h103, 0);
        io(17'h0000f, 1, 8'h0a, 0, 9'h100, 0);
        check(dmaMask, 4'ha);
        io(17'h0001f, 0, 0, 0, 9'h10a, 0);
        io(17'h0000d, 1, 8'h5a, 0, 9'h100, 0);
        check(dmaMask, 4'hf);
        io(17'h0000a, 0, 0, 0, 9'h100, 0);
        io(17'h0000e, 1, 8'h33, 0, 9'h100, 0);
        check(dmaMask, 4'h0);
        seed = lfsr(seed);
        {h, r} = seed;
        io(17'h0000c, 1, 0, 0, 9'h100, 0);
        io(17'h00002, 1, r, 0, 9'h100, 0);
        io(17'h00002, 1, h, 0, 9'h100, 0);
        io(17'h0001c, 1, 0, 0, 9'h100, 0);
        io(17'h00012, 0, 0, 0, {1'b1, r}, 0);
        io(17'h00012, 0, 0, 0, {1'b1, h}, 0);
        io(17'h00065, 1, 8'h03, 0, 9'h100, 0);
        check(nmiCtl[3:0], 4'h3);
        check({posSel, subSel}, 2'b10);
        $display("test dma and nmi done");
        for (int k = 0; k < 3; k++) io(17'h00050 + k, 0, 0, 0, 9'h15a, 0);
        io(17'h00043, 1, 8'h36, 0, 9'h100, 0);
        check(ioWdata, 8'h36);
        @(posedge core_clk);
        kbdCtrlFwdEn <= 1'b1;
        k0 = kbdCnt;
        io(17'h00060, 0, 0, 0, 9'h196, 1);
        @(posedge core_clk);
        kbdCtrlFwdEn <= 1'b0;
        rtcIntEn <= 1'b1;
        io(17'h00062, 0, 0, 0, 9'h000, 0);
        check(kbdCnt - k0, 2);
        io(17'h00072, 1, 8'h0b, 0, 9'h100, 0);
        io(17'h00073, 0, 0, 0, 9'h15a, 0);
        @(posedge core_clk);
        {rtcExtRamEn, rtcXFwdEn, waitCyc} <= 6'h3a;
        io(17'h00072, 1, r, 0, 9'h100, 1);
        check(rtcXIndex, r);
        io(17'h00073, 0, 0, 0, 9'h196, 1);
        $display("test ports done");
        io(17'h00300, 0, 0, 0, 9'h000, 0);
        @(posedge core_clk);
        subtractiveEn <= 1'b1;
        io(17'h00300, 1, 8'h44, 0, 9'h100, 1);
        check({posSel, subSel}, 2'b01);
        io(17'h1fffd, 0, 0, 0, 9'h196, 1);
        io(17'h1ffff, 0, 0, 0, 9'h196, 1);
        k0 = stCnt;
        io(17'h00cfc, 1, 8'h01, 2'b11, 9'h000, 0);
        check(stCnt - k0, 0);
        io(17'h00cfc, 1, 8'h01, 2'b10, 9'h000, 0);
        check({extPciCfg, extPciWrite}, 2'b11);
        check(stCnt - k0, 1);
        @(posedge core_clk);
        {subtractiveEn, varEn, varBase} <= {2'b01, 16'h0130};
        io(17'h00134, 0, 0, 0, 9'h196, 1);
        check({posSel, subSel}, 2'b10);
        $display("test decode done");
        report_and_stop();
    end
endmodule
